// ### rtl/sci_defs.svh
// Offsets, field positions, commands and reset values of the interrupt host port
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

`define SCI_REG_PTR 4'h0
`define SCI_REG_HS_IE 4'h1
`define SCI_REG_VEC 4'h2
`define SCI_REG_PEND 4'h3
`define SCI_REG_DATA 4'h8
`define SCI_REG_MASTER 4'h9

`define SCI_PTR_HIGH_CODE 3'h1
`define SCI_PTR_CLR_MASK 8'he0

`define SCI_CMD_RST_EXT 3'h2
`define SCI_CMD_RST_TX 3'h5
`define SCI_CMD_RST_ERR 3'h6
`define SCI_CMD_RST_IUS 3'h7

`define SCI_HS_EXT_IE 0
`define SCI_HS_TX_IE 1
`define SCI_HS_DTR_REQ 2
`define SCI_HS_RX_MODE_LO 3
`define SCI_HS_RX_SEL 5
`define SCI_HS_FUNC 6
`define SCI_HS_EN 7

`define SCI_RX_OFF 2'h0
`define SCI_RX_FIRST 2'h1
`define SCI_RX_ALL 2'h2
`define SCI_RX_SPECIAL 2'h3

`define SCI_MI_VIS 0
`define SCI_MI_NV 1
`define SCI_MI_MIE 3

`define SCI_ST_NONE 3'h3
`define SCI_SRC_RX 0
`define SCI_SRC_TX 1
`define SCI_SRC_EXT 2

`define SCI_RESET_BYTE 8'h00
`define SCI_RESET_FLAGS 6'h00

`endif

// ### rtl/sci_pkg.sv
// Types of the interrupt host port
package sci_pkg;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic chan_a;
      logic data_sel;
      logic irq_ack_n;
      logic chain_enable_in;
      logic [7:0] data_in;
      logic [1:0] cts_in;
      logic [1:0] carrier_detect_in;
      logic [1:0] sync_in;
   } sci_pins_t;

   typedef struct packed {
      logic rx_char;
      logic rx_special;
      logic tx_empty;
      logic tx_underrun;
      logic baud_zero;
      logic break_det;
      logic abort_det;
      logic end_of_poll;
      logic rx_ready;
      logic tx_ready;
      logic terminal_ready;
   } sci_chan_ev_t;

   typedef struct packed {
      sci_pins_t pin_s1;
      sci_pins_t pin_s2;
      logic rd_prev;
      logic wr_prev;
      logic [1:0][2:0] modem_prev;
      logic [1:0] break_prev;
      logic [1:0] abort_prev;
      logic [1:0] eop_prev;
      logic [1:0][7:0] command_pointer;
      logic [1:0][7:0] handshake_and_int_enable;
      logic [7:0] vector_program;
      logic [7:0] master_int_control;
      logic [5:0] pending_bit;
      logic [5:0] under_service_bit;
      logic [1:0] special;
      logic [1:0] first_done;
      logic [1:0] tx_armed;
      logic drive;
      logic [7:0] data_out;
      logic data_oe;
      logic int_n;
      logic chain_enable_out;
      logic [1:0] handshake_n;
      logic [1:0] dtr_req_n;
      logic [1:0] tx_wr;
      logic [1:0] rx_rd;
      logic [7:0] tx_data;
   } sci_state_t;

endpackage

// ### rtl/sci_host_port.sv
// Interrupt logic and indirect register access of a dual-channel serial controller
`include "sci_defs.svh"

module sci_host_port
   import sci_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire sci_pins_t pins_in,
   input wire sci_chan_ev_t [1:0] chan_ev,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic int_n,
   output logic chain_enable_out,
   output logic [1:0] handshake_n,
   output logic [1:0] dtr_req_n,
   output logic [1:0] tx_wr,
   output logic [1:0] rx_rd,
   output logic [7:0] tx_data
);

   localparam sci_pins_t PIN_IDLE = '{
      cs_n: 1'h1,
      rd_n: 1'h1,
      wr_n: 1'h1,
      chan_a: 1'h0,
      data_sel: 1'h0,
      irq_ack_n: 1'h1,
      chain_enable_in: 1'h0,
      data_in: 8'h00,
      cts_in: 2'h0,
      carrier_detect_in: 2'h0,
      sync_in: 2'h0
   };
   localparam sci_state_t STATE_RESET = '{
      pin_s1: PIN_IDLE,
      pin_s2: PIN_IDLE,
      rd_prev: 1'h0,
      wr_prev: 1'h0,
      modem_prev: 6'h00,
      break_prev: 2'h0,
      abort_prev: 2'h0,
      eop_prev: 2'h0,
      command_pointer: 16'h0000,
      handshake_and_int_enable: 16'h0000,
      vector_program: `SCI_RESET_BYTE,
      master_int_control: `SCI_RESET_BYTE,
      pending_bit: `SCI_RESET_FLAGS,
      under_service_bit: `SCI_RESET_FLAGS,
      special: 2'h0,
      first_done: 2'h0,
      tx_armed: 2'h0,
      drive: 1'h0,
      data_out: `SCI_RESET_BYTE,
      data_oe: 1'h0,
      int_n: 1'h1,
      chain_enable_out: 1'h0,
      handshake_n: 2'h3,
      dtr_req_n: 2'h3,
      tx_wr: 2'h0,
      rx_rd: 2'h0,
      tx_data: `SCI_RESET_BYTE
   };

   sci_state_t state_reg;
   sci_state_t state_next;

   // Source index: channel A first, then receive, transmit, external/status
   function automatic int src(input int ch, input int kind);
      return ch * 3 + kind;
   endfunction

   // Receive interrupt mode field of a channel's enable register
   function automatic logic [1:0] rx_mode_of(input logic [7:0] cfg);
      return cfg[`SCI_HS_RX_MODE_LO +: 2];
   endfunction

   // Pointer after an indirect access: back to register zero, top bits kept
   function automatic logic [7:0] ptr_done(input logic [7:0] p_in);
      return p_in & `SCI_PTR_CLR_MASK;
   endfunction

   // Per-source enables from both channels' enable registers
   function automatic logic [5:0] enable_mask(input logic [1:0][7:0] cfg);
      logic [5:0] m;
      m = 6'h00;
      for (int c = 0; c < 2; c++) begin
         m[src(c, `SCI_SRC_RX)] = rx_mode_of(cfg[c]) != `SCI_RX_OFF;
         m[src(c, `SCI_SRC_TX)] = cfg[c][`SCI_HS_TX_IE];
         m[src(c, `SCI_SRC_EXT)] = cfg[c][`SCI_HS_EXT_IE];
      end
      return m;
   endfunction

   // Pending register layout: channel A receive in bit 5 down to channel B external/status in bit 0
   function automatic logic [7:0] pend_view(input logic [5:0] m);
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < 6; i++) begin
         v[5 - i] = m[i];
      end
      return v;
   endfunction

   // Lowest index set, i.e. highest priority, as one-hot
   function automatic logic [5:0] first_set(input logic [5:0] m);
      logic [5:0] o;
      o = 6'h00;
      for (int i = 5; i >= 0; i--) begin
         if (m[i]) begin
            o = 6'h00;
            o[i] = 1'h1;
         end
      end
      return o;
   endfunction

   // Status code of the highest requesting source
   function automatic logic [2:0] vec_status(input logic [5:0] req, input logic [1:0] special);
      logic [2:0] st;
      st = `SCI_ST_NONE;
      for (int i = 5; i >= 0; i--) begin
         if (req[i]) begin
            case (i % 3)
               `SCI_SRC_RX: st = special[i / 3] ? 3'h3 : 3'h2;
               `SCI_SRC_TX: st = 3'h0;
               default: st = 3'h1;
            endcase
            if (i < 3) begin
               st[2] = 1'h1;
            end
         end
      end
      return st;
   endfunction

   sci_pins_t p;
   logic rd_act;
   logic wr_act;
   logic ack_act;
   logic rd_fall;
   logic wr_fall;
   int ch;
   logic [7:0] ptr;
   logic ptr_high;
   logic [3:0] wr_idx;
   logic [3:0] rd_idx;
   logic [5:0] ie_mask;
   logic [5:0] ie_next;
   logic [5:0] allowed;
   logic [5:0] req;
   logic [7:0] mod_vec;
   logic [7:0] rd_val;
   logic [1:0] rx_mode;
   logic ready;
   logic ext_ev;
   logic [1:0] mode_new;

   always_comb begin
      state_next = state_reg;
      state_next.pin_s1 = pins_in;
      state_next.pin_s2 = state_reg.pin_s1;
      p = state_reg.pin_s2;
      state_next.tx_wr = 2'h0;
      state_next.rx_rd = 2'h0;
      mode_new = 2'h0;

      ack_act = ~p.irq_ack_n & ~p.rd_n;
      rd_act = ~p.cs_n & p.irq_ack_n & ~p.rd_n;
      wr_act = ~p.cs_n & p.irq_ack_n & ~p.wr_n;
      rd_fall = (rd_act | ack_act) & ~state_reg.rd_prev;
      wr_fall = wr_act & ~state_reg.wr_prev;
      state_next.rd_prev = rd_act | ack_act;
      state_next.wr_prev = wr_act;

      ch = p.chan_a ? 0 : 1;
      ptr = state_reg.command_pointer[ch];
      ptr_high = (ptr[5:3] == `SCI_PTR_HIGH_CODE);
      wr_idx = {ptr_high, ptr[2:0]};
      rd_idx = ptr_high ? wr_idx : {2'h0, ptr[1:0]};

      // Enables per source, six sources of one bit each
      ie_mask = enable_mask(state_reg.handshake_and_int_enable);

      // Internal chain: any under-service at or above a source blocks it
      for (int i = 0; i < 6; i++) begin
         allowed[i] = ~|(state_reg.under_service_bit & ((6'h02 << i) - 6'h01));
      end
      req = state_reg.pending_bit & allowed & {6{state_reg.master_int_control[`SCI_MI_MIE]}};

      mod_vec = {state_reg.vector_program[7:4], vec_status(req, state_reg.special),
                 state_reg.vector_program[0]};

      // Register read value
      case (rd_idx)
         `SCI_REG_VEC: rd_val = (ch == 0) ? state_reg.vector_program : mod_vec;
         `SCI_REG_PEND: rd_val = (ch == 0) ? pend_view(state_reg.pending_bit) : 8'h00;
         default: rd_val = 8'h00;
      endcase

      // Pending bits drop with their enable
      state_next.pending_bit = state_reg.pending_bit & ie_mask;

      // Host writes
      if (wr_fall) begin
         if (p.data_sel || wr_idx == `SCI_REG_DATA) begin
            state_next.tx_wr[ch] = 1'h1;
            state_next.tx_data = p.data_in;
            state_next.tx_armed[ch] = 1'h1;
            state_next.pending_bit[src(ch, `SCI_SRC_TX)] = 1'h0;
            if (!p.data_sel) begin
               state_next.command_pointer[ch] = ptr_done(ptr);
            end
         end else begin
            case (wr_idx)
               `SCI_REG_PTR: begin
                  state_next.command_pointer[ch] = p.data_in;
                  case (p.data_in[5:3])
                     `SCI_CMD_RST_EXT: state_next.pending_bit[src(ch, `SCI_SRC_EXT)] = 1'h0;
                     `SCI_CMD_RST_TX: state_next.pending_bit[src(ch, `SCI_SRC_TX)] = 1'h0;
                     `SCI_CMD_RST_ERR: begin
                        state_next.special[ch] = 1'h0;
                        state_next.pending_bit[src(ch, `SCI_SRC_RX)] = 1'h0;
                     end
                     `SCI_CMD_RST_IUS: state_next.under_service_bit =
                        state_reg.under_service_bit & ~first_set(state_reg.under_service_bit);
                     default: ;
                  endcase
               end
               `SCI_REG_HS_IE: begin
                  mode_new = rx_mode_of(p.data_in);
                  if (mode_new != rx_mode_of(state_reg.handshake_and_int_enable[ch])) begin
                     state_next.first_done[ch] = 1'h0;
                  end
                  state_next.handshake_and_int_enable[ch] = p.data_in;
               end
               `SCI_REG_VEC: state_next.vector_program = p.data_in;
               `SCI_REG_MASTER: state_next.master_int_control = p.data_in;
               default: ;
            endcase
            if (wr_idx != `SCI_REG_PTR) begin
               state_next.command_pointer[ch] = ptr_done(ptr);
            end
         end
      end

      // Host reads and acknowledge
      if (rd_fall) begin
         if (ack_act) begin
            if (p.chain_enable_in && |req) begin
               state_next.under_service_bit = state_reg.under_service_bit | first_set(req);
               state_next.drive = ~state_reg.master_int_control[`SCI_MI_NV];
               state_next.data_out = state_reg.master_int_control[`SCI_MI_VIS] ? mod_vec :
                                     state_reg.vector_program;
            end else begin
               state_next.drive = 1'h0;
            end
         end else begin
            state_next.drive = 1'h1;
            if (p.data_sel || rd_idx == `SCI_REG_DATA) begin
               state_next.rx_rd[ch] = 1'h1;
               state_next.data_out = 8'h00;
               if (!state_reg.special[ch]) begin
                  state_next.pending_bit[src(ch, `SCI_SRC_RX)] = 1'h0;
               end
            end else begin
               state_next.data_out = rd_val;
            end
            if (!p.data_sel && rd_idx != `SCI_REG_PTR) begin
               state_next.command_pointer[ch] = ptr_done(ptr);
            end
         end
      end
      state_next.data_oe = (rd_act | ack_act) & (rd_fall ? state_next.drive : state_reg.drive);

      // Source events, applied after host accesses so a set wins over a host clear
      state_next.modem_prev = {p.sync_in[1], p.carrier_detect_in[1], p.cts_in[1],
                               p.sync_in[0], p.carrier_detect_in[0], p.cts_in[0]};
      for (int c = 0; c < 2; c++) begin
         state_next.break_prev[c] = chan_ev[c].break_det;
         state_next.abort_prev[c] = chan_ev[c].abort_det;
         state_next.eop_prev[c] = chan_ev[c].end_of_poll;
         rx_mode = rx_mode_of(state_reg.handshake_and_int_enable[c]);

         if (chan_ev[c].rx_char) begin
            if ((rx_mode == `SCI_RX_FIRST && !state_reg.first_done[c]) || rx_mode == `SCI_RX_ALL) begin
               state_next.pending_bit[src(c, `SCI_SRC_RX)] = 1'h1;
               state_next.first_done[c] = 1'h1;
            end
         end
         if (chan_ev[c].rx_special && rx_mode != `SCI_RX_OFF) begin
            state_next.pending_bit[src(c, `SCI_SRC_RX)] = 1'h1;
            state_next.special[c] = 1'h1;
         end

         if (chan_ev[c].tx_empty && state_reg.tx_armed[c]) begin
            state_next.tx_armed[c] = 1'h0;
            if (ie_mask[src(c, `SCI_SRC_TX)]) begin
               state_next.pending_bit[src(c, `SCI_SRC_TX)] = 1'h1;
            end
         end

         ext_ev = (|(state_next.modem_prev[c] ^ state_reg.modem_prev[c]))
                  | chan_ev[c].tx_underrun | chan_ev[c].baud_zero
                  | (chan_ev[c].break_det & ~state_reg.break_prev[c])
                  | (chan_ev[c].abort_det ^ state_reg.abort_prev[c])
                  | (chan_ev[c].end_of_poll ^ state_reg.eop_prev[c]);
         if (ext_ev && ie_mask[src(c, `SCI_SRC_EXT)]) begin
            state_next.pending_bit[src(c, `SCI_SRC_EXT)] = 1'h1;
         end

         // Block transfer handshake
         ready = state_reg.handshake_and_int_enable[c][`SCI_HS_RX_SEL] ? chan_ev[c].rx_ready :
                 chan_ev[c].tx_ready;
         if (!state_reg.handshake_and_int_enable[c][`SCI_HS_EN]) begin
            state_next.handshake_n[c] = 1'h1;
         end else if (state_reg.handshake_and_int_enable[c][`SCI_HS_FUNC]) begin
            state_next.handshake_n[c] = ~ready;
         end else begin
            state_next.handshake_n[c] = ready;
         end
         state_next.dtr_req_n[c] = state_reg.handshake_and_int_enable[c][`SCI_HS_DTR_REQ] ?
                                   ~chan_ev[c].tx_ready : ~chan_ev[c].terminal_ready;
      end

      // Enables written this cycle gate at once, so no source pends while disabled
      ie_next = enable_mask(state_next.handshake_and_int_enable);
      state_next.pending_bit = state_next.pending_bit & ie_next;

      state_next.int_n = ~(p.chain_enable_in & |req);
      state_next.chain_enable_out = p.chain_enable_in & ~|state_reg.under_service_bit
                                    & ~(ack_act & |req);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign data_out = state_reg.data_out;
   assign data_oe = state_reg.data_oe;
   assign int_n = state_reg.int_n;
   assign chain_enable_out = state_reg.chain_enable_out;
   assign handshake_n = state_reg.handshake_n;
   assign dtr_req_n = state_reg.dtr_req_n;
   assign tx_wr = state_reg.tx_wr;
   assign rx_rd = state_reg.rx_rd;
   assign tx_data = state_reg.tx_data;

endmodule

// ### test/sci_host_port_chk.sv
// Port assertions of the interrupt host port
module sci_host_port_chk
   import sci_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire sci_pins_t pins_in,
   input wire sci_chan_ev_t [1:0] chan_ev,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic int_n,
   input wire logic chain_enable_out,
   input wire logic [1:0] handshake_n,
   input wire logic [1:0] dtr_req_n,
   input wire logic [1:0] tx_wr,
   input wire logic [1:0] rx_rd,
   input wire logic [7:0] tx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic wr_a = !pins_in.cs_n && !pins_in.wr_n && pins_in.data_sel && pins_in.chan_a;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_reset_idle: assert property ($rose(rst_n) |-> int_n && !data_oe && !chain_enable_out && handshake_n == 2'b11)
      else $error("outputs not idle after reset");
   a_int_chain_low: assert property ((!pins_in.chain_enable_in) [*5] |-> int_n)
      else $error("request while chain input low");
   a_chain_out_low: assert property ((!pins_in.chain_enable_in) [*5] |-> !chain_enable_out)
      else $error("chain output high while chain input low");
   a_oe_has_read: assert property (data_oe |-> !$past(pins_in.rd_n, 2) || !$past(pins_in.rd_n, 3)
      || !$past(pins_in.rd_n, 4))
      else $error("bus driven without read strobe");
   a_oe_release: assert property ($rose(pins_in.rd_n) |-> ##[1:5] !data_oe)
      else $error("bus not released after read");
   a_idle_bus_quiet: assert property ((pins_in.rd_n) [*6] |-> !data_oe)
      else $error("bus driven while idle");
   a_tx_wr_cause: assert property (tx_wr[0] |-> $past(wr_a, 2) || $past(wr_a, 3) || $past(wr_a, 4))
      else $error("data write pulse without channel write");
   a_tx_wr_single: assert property (tx_wr[0] |=> !tx_wr[0])
      else $error("data write pulse too long");
   a_tx_data_hold: assert property (tx_wr == 2'b00 |-> $stable(tx_data))
      else $error("write data moved without pulse");
   c_int_request: cover property (!int_n);
   c_ack_vector: cover property (data_oe && !pins_in.irq_ack_n);
   c_tx_write: cover property (tx_wr[0]);
endmodule
bind sci_host_port sci_host_port_chk sci_host_port_chk_i (.clock(clock), .rst_n(rst_n), .pins_in(pins_in),
   .chan_ev(chan_ev), .data_out(data_out), .data_oe(data_oe), .int_n(int_n), .chain_enable_out(chain_enable_out),
   .handshake_n(handshake_n), .dtr_req_n(dtr_req_n), .tx_wr(tx_wr), .rx_rd(rx_rd), .tx_data(tx_data));

// ### test/sci_cpu_model.sv
// Host processor model driving the controller's bus pins
module sci_cpu_model
   import sci_pkg::*;
(
   input wire logic clock,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output sci_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, irq_ack_n: 1'b1, chain_enable_in: 1'b1, default: '0};
   end
   // Kind 0 write, 1 read, 2 acknowledge; strobe low five clocks, then idle five
   task automatic access(input int kind, input logic a, input logic d, input logic [7:0] wd,
      output logic [7:0] rdat, output logic oe);
      @(negedge clock);
      pins.chan_a = a;
      pins.data_sel = d;
      pins.cs_n = (kind == 2);
      pins.irq_ack_n = (kind != 2);
      pins.rd_n = (kind == 0);
      pins.wr_n = (kind != 0);
      if (kind == 0) pins.data_in = wd;
      repeat (5) @(negedge clock);
      rdat = data_out;
      oe = data_oe;
      pins.cs_n = 1'b1;
      pins.rd_n = 1'b1;
      pins.wr_n = 1'b1;
      pins.irq_ack_n = 1'b1;
      pins.data_in = ~pins.data_in;
      repeat (5) @(negedge clock);
   endtask
endmodule

// ### test/serial_ctrl_interrupt_host_port_test.sv
// Self-checking bench of the interrupt host port
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module serial_ctrl_interrupt_host_port_test;
   import sci_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   sci_pins_t pins;
   sci_chan_ev_t [1:0] chan_ev = '0;
   logic [7:0] data_out, tx_data, rd;
   logic data_oe, int_n, chain_enable_out, oe;
   logic [1:0] handshake_n, dtr_req_n, tx_wr, rx_rd;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int txw = 0;
   int rxr = 0;
   always #20 clock = ~clock;
   sci_host_port sci_host_port_i (.clock(clock), .rst_n(rst_n), .pins_in(pins), .chan_ev(chan_ev),
      .data_out(data_out), .data_oe(data_oe), .int_n(int_n), .chain_enable_out(chain_enable_out),
      .handshake_n(handshake_n), .dtr_req_n(dtr_req_n), .tx_wr(tx_wr), .rx_rd(rx_rd), .tx_data(tx_data));
   sci_cpu_model sci_cpu_model_i (.clock(clock), .data_out(data_out), .data_oe(data_oe), .pins(pins));
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (tx_wr[0] === 1'b1) txw++;
      if (rx_rd[0] === 1'b1) rxr++;
      if (cycles == 3000) begin
         err_total++;
         print_verdict();
      end
   end
   // Pointer write followed by the write it selects
   task automatic wr(input logic a, input logic [7:0] p, input logic [7:0] v);
      sci_cpu_model_i.access(0, a, 1'b0, p, rd, oe);
      sci_cpu_model_i.access(0, a, 1'b0, v, rd, oe);
   endtask
   task automatic cmd(input logic [7:0] p);
      sci_cpu_model_i.access(0, 1'b1, 1'b0, p, rd, oe);
   endtask
   // Read or acknowledge, with a pointer write first where needed
   task automatic chk_rd(input string n, input int kind, input logic a, input logic [7:0] p, input logic [7:0] e);
      if (kind == 1 && p != 8'h00) sci_cpu_model_i.access(0, a, 1'b0, p, rd, oe);
      sci_cpu_model_i.access(kind, a, 1'b0, 8'h00, rd, oe);
      `CHK(n, e, rd)
      `CHK(n, 1'b1, oe)
   endtask
   task automatic pulse_tx(input int ch);
      @(negedge clock) chan_ev[ch].tx_empty = 1'b1;
      @(negedge clock) chan_ev[ch].tx_empty = 1'b0;
      repeat (5) @(negedge clock);
   endtask
   initial begin
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      `CHK("int_n", 1'b1, int_n)
      chk_rd("pending", 1, 1'b1, 8'h03, 8'h00);
      wr(1'b1, 8'h02, 8'hA0);
      wr(1'b1, 8'h01, 8'h12);
      wr(1'b1, 8'h09, 8'h09);
      chk_rd("vector a", 1, 1'b1, 8'h02, 8'hA0);
      chk_rd("vector b", 1, 1'b0, 8'h02, 8'hA6);
      chk_rd("vector alias", 1, 1'b1, 8'h06, 8'hA0);
      $display("end of setup");
      pulse_tx(1);
      pulse_tx(0);
      chk_rd("pending", 1, 1'b1, 8'h03, 8'h00);
      sci_cpu_model_i.access(0, 1'b1, 1'b1, 8'h5A, rd, oe);
      `CHK("tx_data", 8'h5A, tx_data)
      `CHK("tx writes", 1, txw)
      pulse_tx(0);
      @(negedge clock) chan_ev[0].rx_char = 1'b1;
      @(negedge clock) chan_ev[0].rx_char = 1'b0;
      repeat (5) @(negedge clock);
      chk_rd("pending", 1, 1'b1, 8'h03, 8'h30);
      `CHK("int_n", 1'b0, int_n)
      sci_cpu_model_i.pins.chain_enable_in = 1'b0;
      repeat (6) @(negedge clock);
      `CHK("int_n chain", 1'b1, int_n)
      sci_cpu_model_i.pins.chain_enable_in = 1'b1;
      repeat (6) @(negedge clock);
      chk_rd("ack rx", 2, 1'b1, 8'h00, 8'hAC);
      `CHK("chain_out", 1'b0, chain_enable_out)
      cmd(8'h38);
      cmd(8'h30);
      chk_rd("ack tx", 2, 1'b1, 8'h00, 8'hA8);
      cmd(8'h38);
      cmd(8'h28);
      `CHK("int_n", 1'b1, int_n)
      `CHK("chain_out", 1'b1, chain_enable_out)
      @(negedge clock) chan_ev[0].rx_special = 1'b1;
      @(negedge clock) chan_ev[0].rx_special = 1'b0;
      repeat (5) @(negedge clock);
      chk_rd("ack special", 2, 1'b1, 8'h00, 8'hAE);
      cmd(8'h38);
      cmd(8'h30);
      $display("end of priority");
      wr(1'b1, 8'h01, 8'h13);
      for (int i = 0; i < 3; i++) begin
         if (i == 0) sci_cpu_model_i.pins.cts_in[0] = 1'b1;
         else chan_ev[0].abort_det = (i == 1);
         repeat (6) @(negedge clock);
         chk_rd("ext pending", 1, 1'b1, 8'h03, 8'h08);
         cmd(8'h10);
      end
      chan_ev[0].rx_ready = 1'b1;
      chan_ev[0].tx_ready = 1'b1;
      wr(1'b1, 8'h01, 8'hF7);
      `CHK("request", 1'b0, handshake_n[0])
      `CHK("dtr request", 1'b0, dtr_req_n[0])
      wr(1'b1, 8'h01, 8'hB7);
      `CHK("wait ready", 1'b1, handshake_n[0])
      chan_ev[0].rx_ready = 1'b0;
      repeat (5) @(negedge clock);
      `CHK("wait busy", 1'b0, handshake_n[0])
      $display("end of handshake");
      wr(1'b1, 8'h01, 8'h08);
      @(negedge clock) chan_ev[0].rx_char = 1'b1;
      @(negedge clock) chan_ev[0].rx_char = 1'b0;
      repeat (5) @(negedge clock);
      chk_rd("first char", 1, 1'b1, 8'h03, 8'h20);
      sci_cpu_model_i.access(1, 1'b1, 1'b1, 8'h00, rd, oe);
      `CHK("data read", 8'h00, rd)
      `CHK("rx reads", 1, rxr)
      @(negedge clock) chan_ev[0].rx_char = 1'b1;
      @(negedge clock) chan_ev[0].rx_char = 1'b0;
      repeat (5) @(negedge clock);
      chk_rd("second char", 1, 1'b1, 8'h03, 8'h00);
      @(negedge clock) chan_ev[0].rx_special = 1'b1;
      @(negedge clock) chan_ev[0].rx_special = 1'b0;
      repeat (5) @(negedge clock);
      chk_rd("special after first", 1, 1'b1, 8'h03, 8'h20);
      wr(1'b1, 8'h09, 8'h0A);
      sci_cpu_model_i.access(2, 1'b1, 1'b0, 8'h00, rd, oe);
      `CHK("no vector", 1'b0, oe)
      `CHK("chain_out", 1'b0, chain_enable_out)
      $display("end of receive modes");
      print_verdict();
   end
endmodule
